// >>> include/facility_codec_pkg.sv
// Shared codes, types and layouts for the facility component codec
package facility_codec_pkg;

  // ----------------------------------------------------------------
  // Tag fields
  // ----------------------------------------------------------------
  localparam int FORM_BIT = 5;
  localparam int CLASS_HI = 7;
  localparam int CLASS_LO = 6;
  localparam logic [1:0] CLASS_UNIVERSAL = 2'h0;
  localparam logic [1:0] CLASS_APPLICATION = 2'h1;
  localparam logic [1:0] CLASS_CONTEXT = 2'h2;
  localparam logic [1:0] CLASS_PRIVATE = 2'h3;

  // ----------------------------------------------------------------
  // Length octet
  // ----------------------------------------------------------------
  localparam int LONG_BIT = 7;
  localparam logic [7:0] SHORT_MAX = 8'h7f;
  localparam logic [6:0] LONG_EXTRA = 7'h01;
  localparam logic [7:0] LONG_PREFIX = 8'h81;

  // ----------------------------------------------------------------
  // Component and element tags
  // ----------------------------------------------------------------
  localparam logic [7:0] TAG_INVOKE = 8'ha1;
  localparam logic [7:0] TAG_RESULT = 8'ha2;
  localparam logic [7:0] TAG_ERROR = 8'ha3;
  localparam logic [7:0] TAG_REJECT = 8'ha4;
  localparam logic [7:0] TAG_INVOKE_ID = 8'h02;
  localparam logic [7:0] TAG_LINKED_ID = 8'h80;
  localparam logic [7:0] TAG_NULL = 8'h05;
  localparam logic [7:0] TAG_OP_VALUE = 8'h02;
  localparam logic [7:0] TAG_ERR_VALUE = 8'h02;
  localparam logic [7:0] ID_LEN = 8'h01;
  localparam logic [7:0] NULL_LEN = 8'h00;

  // ----------------------------------------------------------------
  // Operation value codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_VALUE_QUERY = 8'h8c;
  localparam logic [7:0] OP_SET_VALUE = 8'h8d;
  localparam logic [7:0] OP_REQUEST_FEATURE = 8'h8f;
  localparam logic [7:0] OP_ABORT = 8'hbe;
  localparam logic [7:0] OP_REDIRECT_CALL = 8'hce;
  localparam logic [7:0] OP_HOLD_CALLER = 8'hcf;
  localparam logic [7:0] OP_RETRIEVE_HOLD = 8'hd0;
  localparam logic [7:0] OP_DROP_TARGET = 8'hd1;
  localparam logic [7:0] OP_CALL_STATUS = 8'hd2;
  localparam logic [7:0] OP_USER_DATA = 8'hd3;

  typedef enum logic [1:0] {
    COMP_INVOKE = 2'h0,
    COMP_RESULT = 2'h1,
    COMP_ERROR = 2'h2,
    COMP_REJECT = 2'h3
  } comp_e;

  // Decoded component descriptor
  typedef struct packed {
    comp_e ctype;
    logic bad;
    logic [7:0] comp_len;
    logic has_iid;
    logic iid_null;
    logic [7:0] iid;
    logic has_link;
    logic [7:0] link_id;
    logic has_val;
    logic [7:0] val;
  } comp_desc_s;

  // Encoder request: code is the operation or error value
  typedef struct packed {
    comp_e ctype;
    logic want_link;
    logic [7:0] code;
    logic [7:0] arg_len;
  } enc_req_s;

  localparam int DESC_W = $bits(comp_desc_s);

endpackage

// >>> hw/two_entry_buffer.sv
// Two-entry skid buffer with registered outputs
`timescale 1ns/100ps
module two_entry_buffer #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic s_valid,
  output logic s_ready,
  input wire logic [WIDTH-1:0] s_data,
  output logic m_valid,
  input wire logic m_ready,
  output logic [WIDTH-1:0] m_data
);

  logic skid_valid, next_skid_valid, next_m_valid;
  logic [WIDTH-1:0] skid, next_skid, next_m_data;
  logic accept, out_free;

  initial begin
    if (WIDTH < 1) $error("two_entry_buffer: WIDTH must be positive");
  end

  // Ready depends only on the skid flop, so the source never sees a
  // combinational path from m_ready.
  assign s_ready = !skid_valid;
  assign accept = s_valid && s_ready;
  assign out_free = !m_valid || m_ready;

  always_comb begin
    next_m_valid = m_valid;
    next_m_data = m_data;
    next_skid_valid = skid_valid;
    next_skid = skid;
    if (out_free) begin
      if (skid_valid) begin
        next_m_valid = 1'b1;
        next_m_data = skid;
        next_skid_valid = 1'b0;
      end else begin
        next_m_valid = accept;
        if (accept) next_m_data = s_data;
      end
    end else if (accept) begin
      next_skid_valid = 1'b1;
      next_skid = s_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      m_valid <= 1'b0;
      m_data <= '0;
      skid_valid <= 1'b0;
      skid <= '0;
    end else begin
      m_valid <= next_m_valid;
      m_data <= next_m_data;
      skid_valid <= next_skid_valid;
      skid <= next_skid;
    end
  end

endmodule // two_entry_buffer

// >>> hw/facility_component_codec.sv
// Facility component decoder and header encoder
// Functional notes
// R1 - Tag bit 6: 0 primitive element, 1 constructor holding nested elements.
// R2 - Lengths up to 127 use one octet, bit 8 clear.
// R3 - Longer lengths: prefix bit 8 set, low bits count the extra octets.
// R4 - Long length value runs MSB first across the following octets.
// R5 - Long length uses fewest octets, no leading zero octet.
// R6 - Long length field is exactly two octets here.
// R7 - Component type tags a1, a2, a3, a4 select the structure.
// R8 - Identifier tags: invoke 02, linked 80, null 05.
// R9 - Invoke and linked identifiers one octet; null has zero length.
// R10 - Result and error answers carry the answered invoke identifier.
// R11 - Reject copies the offending identifier, else sends a null element.
// R12 - Invoke assigns its own identifier; other types reuse a received one.
// R13 - Optional linked identifier equals a received invoke identifier.
// R14 - Operation value tag is 02, value encoded as an integer.
// R15 - Operation codes 8c, 8d, 8f, be, ce, cf, d0, d1, d2, d3.
// R16 - Error value tag is 02, value an integer.
// R17 - Tag bits 8 and 7 give the class.
// R18 - Every tag is a single octet.
// R19 - Component length excludes type tag and its own length octets.
// R20 - Flag malformed: unknown type, bad long prefix, identifier length not one.
`timescale 1ns/100ps
module facility_component_codec
  import facility_codec_pkg::*;
#(
  parameter int HDR_MAX = 12
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic desc_valid,
  input wire logic desc_ready,
  output comp_desc_s desc,
  input wire logic req_valid,
  output logic req_ready,
  input wire enc_req_s req,
  output logic enc_error,
  output logic [7:0] tx_byte,
  output logic tx_valid,
  input wire logic tx_ready
);

  initial begin
    // Invoke with link in long form is type, 81, length and nine octets
    if (HDR_MAX < 12) $error("HDR_MAX too small for the longest header");
  end

  // ----------------------------------------------------------------
  // Decoder
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    D_TYPE = 7'h01, D_LEN = 7'h02, D_LLEN = 7'h04, D_TAG = 7'h08,
    D_ELEN = 7'h10, D_EVAL = 7'h20, D_EMIT = 7'h40
  } dec_state_e;
  typedef enum logic [2:0] {
    K_SKIP = 3'h0, K_IID = 3'h1, K_NULL = 3'h2, K_LINK = 3'h3, K_VAL = 3'h4
  } elem_kind_e;

  dec_state_e st, next_st;
  elem_kind_e kind, next_kind;
  comp_desc_s d, next_d;
  logic [7:0] rem, next_rem, erem, next_erem;
  logic seen, next_seen, cons, next_cons, next_rx_ready;
  logic [7:0] inv_id, next_inv_id, last_id, next_last_id;
  logic inv_ok, next_inv_ok, last_ok, next_last_ok;
  logic fire, last, push, buf_ready;

  assign fire = rx_valid && rx_ready;
  assign last = (rem == 8'h01);

  always_comb begin
    next_st = st;
    next_kind = kind;
    next_d = d;
    next_rem = rem;
    next_erem = erem;
    next_seen = seen;
    next_cons = cons;
    push = 1'b0;
    unique case (st)
      D_TYPE: if (fire) begin
        next_d = '0;
        next_seen = 1'b0;
        next_st = D_LEN;
        unique case (rx_byte) // R7
          TAG_INVOKE: next_d.ctype = COMP_INVOKE;
          TAG_RESULT: next_d.ctype = COMP_RESULT;
          TAG_ERROR: next_d.ctype = COMP_ERROR;
          TAG_REJECT: next_d.ctype = COMP_REJECT;
          default: next_d.bad = 1'b1; // R20
        endcase
      end
      D_LEN: if (fire) begin
        if (rx_byte[LONG_BIT]) begin // R3
          // Without a usable length the rest cannot be delimited
          if (rx_byte[6:0] == LONG_EXTRA) begin // R6
            next_st = D_LLEN;
          end else begin
            next_d.bad = 1'b1; // R20
            next_st = D_EMIT;
          end
        end else begin
          next_rem = rx_byte; // R2 R19
          next_d.comp_len = rx_byte;
          if (rx_byte == 8'h00) begin
            next_d.bad = 1'b1;
            next_st = D_EMIT;
          end else begin
            next_st = D_TAG;
          end
        end
      end
      D_LLEN: if (fire) begin
        next_rem = rx_byte; // R4
        next_d.comp_len = rx_byte;
        if (rx_byte <= SHORT_MAX) begin // R5
          next_d.bad = 1'b1;
          next_st = (rx_byte == 8'h00) ? D_EMIT : D_TAG;
        end else begin
          next_st = D_TAG;
        end
      end
      D_TAG: if (fire) begin
        next_rem = rem - 8'h01;
        next_seen = 1'b1;
        next_cons = rx_byte[FORM_BIT]; // R1
        next_kind = K_SKIP;
        // One octet per tag; class bits need no separate handling
        if (!seen) begin // R18 R17
          if (rx_byte == TAG_INVOKE_ID) next_kind = K_IID; // R8
          else if (rx_byte == TAG_NULL) next_kind = K_NULL; // R8
          else next_d.bad = 1'b1;
        end else if (rx_byte == TAG_LINKED_ID && !d.has_link &&
                     d.ctype == COMP_INVOKE) begin
          next_kind = K_LINK; // R13
          next_d.has_link = 1'b1;
        end else if (rx_byte == TAG_OP_VALUE && !d.has_val) begin
          next_kind = K_VAL; // R14 R16
          next_d.has_val = 1'b1;
        end
        if (last) begin
          next_d.bad = 1'b1;
          next_st = D_EMIT;
        end else begin
          next_st = D_ELEN;
        end
      end
      D_ELEN: if (fire) begin
        next_rem = rem - 8'h01;
        next_erem = rx_byte;
        if ((kind == K_IID || kind == K_LINK) && rx_byte != ID_LEN)
          next_d.bad = 1'b1; // R9 R20
        if (kind == K_NULL) begin
          next_d.iid_null = 1'b1;
          if (rx_byte != NULL_LEN) next_d.bad = 1'b1; // R9
        end
        if (rx_byte[LONG_BIT]) begin
          // Long element lengths are not followed; mark and skip out
          next_d.bad = 1'b1;
          next_erem = rem;
          next_kind = K_SKIP;
          next_st = last ? D_EMIT : D_EVAL;
        end else if (cons || rx_byte == 8'h00) begin
          next_st = last ? D_EMIT : D_TAG; // R1
        end else if (last) begin
          next_d.bad = 1'b1;
          next_st = D_EMIT;
        end else begin
          next_st = D_EVAL;
        end
      end
      D_EVAL: if (fire) begin
        next_rem = rem - 8'h01;
        next_erem = erem - 8'h01;
        unique case (kind)
          K_IID: begin
            next_d.iid = rx_byte;
            next_d.has_iid = 1'b1;
          end
          K_LINK: next_d.link_id = rx_byte;
          K_VAL: next_d.val = rx_byte; // R15
          default: ;
        endcase
        if (last) begin
          if (erem != 8'h01) next_d.bad = 1'b1;
          next_st = D_EMIT;
        end else if (erem == 8'h01) begin
          next_st = D_TAG;
        end
      end
      D_EMIT: if (buf_ready) begin
        push = 1'b1;
        next_st = D_TYPE;
      end
    endcase
    next_rx_ready = (next_st != D_EMIT);
  end

  // ----------------------------------------------------------------
  // Identifier memory
  // ----------------------------------------------------------------
  always_comb begin
    next_inv_id = inv_id;
    next_inv_ok = inv_ok;
    next_last_id = last_id;
    next_last_ok = last_ok;
    if (push) begin
      next_last_id = d.iid;
      next_last_ok = d.has_iid;
      if (d.ctype == COMP_INVOKE && d.has_iid && !d.bad) begin
        next_inv_id = d.iid;
        next_inv_ok = 1'b1;
      end
    end
  end

  two_entry_buffer #(.WIDTH(DESC_W)) desc_buf (
    .clk(clk),
    .reset(reset),
    .s_valid(push),
    .s_ready(buf_ready),
    .s_data(d),
    .m_valid(desc_valid),
    .m_ready(desc_ready),
    .m_data(desc)
  );

  // ----------------------------------------------------------------
  // Encoder
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {E_IDLE = 2'h1, E_SEND = 2'h2} enc_state_e;

  enc_state_e est, next_est;
  logic [7:0] hdr [HDR_MAX];
  logic [7:0] next_hdr [HDR_MAX];
  logic [7:0] e [9];
  logic [3:0] hdr_n, next_hdr_n, idx, next_idx, en, off;
  logic [8:0] clen;
  logic [7:0] own_id, next_own_id, next_tx_byte;
  logic next_tx_valid, next_req_ready, next_enc_error, link_ok;

  always_comb begin
    for (int i = 0; i < 9; i++) e[i] = 8'h00;
    en = 4'h0;
    link_ok = req.want_link && inv_ok;
    if (req.ctype == COMP_REJECT && !last_ok) begin
      e[0] = TAG_NULL; // R11
      e[1] = NULL_LEN;
      en = 4'h2;
    end else begin
      e[0] = TAG_INVOKE_ID;
      e[1] = ID_LEN; // R9
      unique case (req.ctype)
        COMP_INVOKE: e[2] = own_id; // R12
        COMP_REJECT: e[2] = last_id; // R11
        default: e[2] = inv_id; // R10 R12
      endcase
      en = 4'h3;
    end
    if (req.ctype == COMP_INVOKE && link_ok) begin
      e[en] = TAG_LINKED_ID; // R13
      e[en + 4'h1] = ID_LEN;
      e[en + 4'h2] = inv_id;
      en = en + 4'h3;
    end
    if (req.ctype == COMP_INVOKE || req.ctype == COMP_ERROR) begin
      e[en] = (req.ctype == COMP_ERROR) ? TAG_ERR_VALUE : TAG_OP_VALUE;
      e[en + 4'h1] = ID_LEN; // R14 R16
      e[en + 4'h2] = req.code;
      en = en + 4'h3;
    end
    clen = {5'h00, en} + {1'b0, req.arg_len}; // R19
  end

  always_comb begin
    next_est = est;
    next_hdr = hdr;
    next_hdr_n = hdr_n;
    next_idx = idx;
    next_own_id = own_id;
    next_tx_byte = tx_byte;
    next_tx_valid = tx_valid;
    next_enc_error = 1'b0;
    off = 4'h2;
    unique case (est)
      E_IDLE: if (req_valid && req_ready) begin
        if (clen[8]) begin
          next_enc_error = 1'b1; // R6
        end else begin
          for (int i = 0; i < HDR_MAX; i++) next_hdr[i] = 8'h00;
          next_hdr[0] = (req.ctype == COMP_INVOKE) ? TAG_INVOKE :
                        (req.ctype == COMP_RESULT) ? TAG_RESULT :
                        (req.ctype == COMP_ERROR) ? TAG_ERROR : TAG_REJECT;
          if (clen[7:0] > SHORT_MAX) begin
            next_hdr[1] = LONG_PREFIX; // R3 R5 R6
            next_hdr[2] = clen[7:0]; // R4
            off = 4'h3;
          end else begin
            next_hdr[1] = clen[7:0]; // R2
          end
          for (int i = 0; i < 9; i++) next_hdr[off + 4'(i)] = e[i];
          next_hdr_n = off + en;
          if (req.ctype == COMP_INVOKE) next_own_id = own_id + 8'h01;
          next_tx_byte = next_hdr[0];
          next_tx_valid = 1'b1;
          next_idx = 4'h1;
          next_est = E_SEND;
        end
      end
      E_SEND: if (tx_ready) begin
        if (idx == hdr_n) begin
          next_tx_valid = 1'b0;
          next_est = E_IDLE;
        end else begin
          next_tx_byte = hdr[idx];
          next_idx = idx + 4'h1;
        end
      end
    endcase
    next_req_ready = (next_est == E_IDLE);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= D_TYPE;
      kind <= K_SKIP;
      d <= '0;
      rem <= 8'h00;
      erem <= 8'h00;
      seen <= 1'b0;
      cons <= 1'b0;
      rx_ready <= 1'b1;
      inv_id <= 8'h00;
      inv_ok <= 1'b0;
      last_id <= 8'h00;
      last_ok <= 1'b0;
      est <= E_IDLE;
      for (int i = 0; i < HDR_MAX; i++) hdr[i] <= 8'h00;
      hdr_n <= 4'h0;
      idx <= 4'h0;
      own_id <= 8'h00;
      tx_byte <= 8'h00;
      tx_valid <= 1'b0;
      req_ready <= 1'b1;
      enc_error <= 1'b0;
    end else begin
      st <= next_st;
      kind <= next_kind;
      d <= next_d;
      rem <= next_rem;
      erem <= next_erem;
      seen <= next_seen;
      cons <= next_cons;
      rx_ready <= next_rx_ready;
      inv_id <= next_inv_id;
      inv_ok <= next_inv_ok;
      last_id <= next_last_id;
      last_ok <= next_last_ok;
      est <= next_est;
      hdr <= next_hdr;
      hdr_n <= next_hdr_n;
      idx <= next_idx;
      own_id <= next_own_id;
      tx_byte <= next_tx_byte;
      tx_valid <= next_tx_valid;
      req_ready <= next_req_ready;
      enc_error <= next_enc_error;
    end
  end

endmodule // facility_component_codec

// >>> testbench/facility_codec_checker.sv
// Port-level assertions for the facility component codec
`timescale 1ns/100ps
module facility_codec_checker
  import facility_codec_pkg::*;
#(
  parameter int HDR_MAX = 12
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic desc_valid,
  input wire logic desc_ready,
  input wire comp_desc_s desc,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire enc_req_s req,
  input wire logic enc_error,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  input wire logic tx_ready
);
  // --------------------------------------------------------------
  // Header octet tracking
  // --------------------------------------------------------------
  logic take, shot, inv_ok;
  logic [7:0] n, b1, b2, last, arg, inv_id, t;
  comp_e ct;
  assign take = req_valid && req_ready;
  assign shot = tx_valid && tx_ready;
  assign t = (b1 == LONG_PREFIX) ? 8'h03 : 8'h02;
  assign inv_ok = desc.ctype == COMP_INVOKE && !desc.bad && !desc.iid_null;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  always_ff @(posedge clk) begin
    if (reset) begin
      n <= 8'h00;
      b1 <= 8'h00;
      inv_id <= 8'h00;
    end else begin
      if (take) begin
        n <= 8'h00;
        arg <= req.arg_len;
        ct <= req.ctype;
      end else if (shot) begin
        n <= n + 8'h01;
        last <= tx_byte;
        if (n == 8'h01) b1 <= tx_byte;
        if (n == 8'h02) b2 <= tx_byte;
      end
      // Answers reuse the identifier of the last good invoke handed out
      if (desc_valid && desc_ready && inv_ok && desc.has_iid) inv_id <= desc.iid;
    end
  end
  property p_type_tag;
    take && req.arg_len < 8'hf0 |=> tx_valid && tx_byte == TAG_INVOKE + 8'(ct);
  endproperty
  a_type_tag: assert property (p_type_tag) else $error("bad type tag");
  property p_tag_class;
    shot && n == 8'h00 |-> tx_byte[CLASS_HI:CLASS_LO] == CLASS_CONTEXT
      && tx_byte[FORM_BIT];
  endproperty
  a_tag_class: assert property (p_tag_class) else $error("bad tag class");
  property p_long_prefix;
    shot && n == 8'h01 && tx_byte[LONG_BIT] |-> tx_byte == LONG_PREFIX;
  endproperty
  a_long_prefix: assert property (p_long_prefix) else $error("bad prefix");
  property p_long_min;
    shot && n == 8'h02 && b1 == LONG_PREFIX |-> tx_byte > SHORT_MAX;
  endproperty
  a_long_min: assert property (p_long_min) else $error("long not minimal");
  property p_id_tag;
    shot && n == t |-> tx_byte == TAG_INVOKE_ID
      || (tx_byte == TAG_NULL && ct == COMP_REJECT);
  endproperty
  a_id_tag: assert property (p_id_tag) else $error("bad id tag");
  property p_id_len;
    shot && n == t + 8'h01 |-> tx_byte == (last == TAG_NULL ? NULL_LEN : ID_LEN);
  endproperty
  a_id_len: assert property (p_id_len) else $error("bad id length");
  property p_answer_id;
    shot && n == t + 8'h02 && (ct == COMP_RESULT || ct == COMP_ERROR)
      |-> tx_byte == inv_id;
  endproperty
  a_answer_id: assert property (p_answer_id) else $error("wrong answer id");
  property p_length;
    $rose(req_ready) && n != 8'h00 |-> (b1 == LONG_PREFIX ? b2 : b1)
      == n - t + arg;
  endproperty
  a_length: assert property (p_length) else $error("length mismatch");
  property p_refuse;
    enc_error |-> !tx_valid && req_ready;
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused header sent");
endmodule // facility_codec_checker

bind facility_component_codec facility_codec_checker #(.HDR_MAX(HDR_MAX))
  u_facility_codec_checker (.clk(clk), .reset(reset),
  .desc_valid(desc_valid), .desc_ready(desc_ready), .desc(desc),
  .req_valid(req_valid), .req_ready(req_ready), .req(req),
  .enc_error(enc_error), .tx_byte(tx_byte), .tx_valid(tx_valid),
  .tx_ready(tx_ready));

// >>> testbench/peer_sink.sv
// Far-end peer model that takes header octets, promptly or with stalls
`timescale 1ns/100ps
module peer_sink (
  input wire logic clk,
  input wire logic slow,
  output logic tx_ready
);
  // --------------------------------------------------------------
  // Acceptance
  // --------------------------------------------------------------
  integer seed = 32'h3cca5a61;
  initial tx_ready = 1'b1;
  // A stalling peer must not cost the encoder any octet
  always @(negedge clk) tx_ready <= slow ? 1'($random(seed)) : 1'b1;
endmodule // peer_sink

// >>> testbench/facility_component_codec_tb.sv
// Self-checking bench for the facility component codec
`timescale 1ns/100ps
module facility_component_codec_tb
  import facility_codec_pkg::*;
;
  // --------------------------------------------------------------
  // Stimulus, expectations and monitors
  // --------------------------------------------------------------
  logic clk, reset, rx_valid, rx_ready, desc_valid, desc_ready;
  logic req_valid, req_ready, enc_error, tx_valid, tx_ready, slow, lnul;
  logic [7:0] rx_byte, tx_byte, own, inv, last, id;
  comp_desc_s desc;
  enc_req_s req;
  comp_desc_s dq[$];
  logic [8:0] tq[$];
  logic [7:0] m[$];
  logic [7:0] ops[10];
  int num_errors, num_checks, cyc, i;
  integer seed = 32'h3cca5a61;
  integer rseed = 32'h3cca5a61;
  facility_component_codec #(.HDR_MAX(12)) u_facility_component_codec (
    .clk(clk), .reset(reset), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .desc_valid(desc_valid), .desc_ready(desc_ready),
    .desc(desc), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .enc_error(enc_error), .tx_byte(tx_byte), .tx_valid(tx_valid),
    .tx_ready(tx_ready));
  peer_sink u_peer_sink (.clk(clk), .slow(slow), .tx_ready(tx_ready));
  initial begin
    clk = 1'b0;
    desc_ready = 1'b1;
    forever #10 clk = ~clk;
  end
  always @(negedge clk) desc_ready <= 1'($random(rseed));
  function automatic comp_desc_s mk(comp_e c, logic [7:0] l,
      logic [8:0] d, logic [8:0] lk, logic [8:0] v);
    mk = '0;
    mk.ctype = c;
    mk.comp_len = l;
    mk.iid_null = d[8];
    mk.has_iid = !d[8];
    mk.iid = d[8] ? 8'h00 : d[7:0];
    {mk.has_link, mk.link_id} = lk;
    {mk.has_val, mk.val} = v;
  endfunction
  function automatic comp_desc_s bd();
    bd = '0;
    bd.bad = 1'b1;
  endfunction
  // Fields that carry no meaning for the kind of element are zeroed
  function automatic comp_desc_s norm(comp_desc_s x);
    comp_desc_s r;
    r = '0;
    r.bad = x.bad;
    if (x.bad === 1'b0) begin
      r.ctype = x.ctype;
      r.comp_len = x.comp_len;
      r.iid_null = x.iid_null;
      r.has_iid = x.has_iid & !x.iid_null;
      r.has_link = x.has_link;
      r.has_val = x.has_val;
      if (r.has_iid) r.iid = x.iid;
      if (x.has_link) r.link_id = x.link_id;
      if (x.has_val) r.val = x.val;
    end
    return r;
  endfunction
  task put(input logic [7:0] b);
    rx_byte = b;
    rx_valid = 1'b1;
    while (rx_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
  endtask
  task comp(input comp_desc_s e);
    dq.push_back(norm(e));
    if (!e.bad) begin
      if (e.ctype == COMP_INVOKE) inv = e.iid;
      last = e.iid;
      lnul = e.iid_null;
    end
    foreach (m[k]) put(m[k]);
  endtask
  task idle();
    rx_valid = 1'b0;
    while (dq.size() != 0) @(negedge clk);
  endtask
  task nt(input logic [7:0] a, b, c, input int k);
    tq.push_back({1'b0, a});
    if (k > 1) tq.push_back({1'b0, b});
    if (k > 2) tq.push_back({1'b0, c});
  endtask
  task enc(input comp_e c, input logic lk, input logic [7:0] code, a);
    int len;
    logic nul;
    nul = c == COMP_REJECT && lnul;
    len = int'(a) + (nul ? 2 : 3);
    if (c == COMP_INVOKE || c == COMP_ERROR) len = len + 3;
    if (c == COMP_INVOKE && lk) len = len + 3;
    if (len > 255) tq.push_back(9'h100);
    else begin
      nt(TAG_INVOKE + 8'(c), LONG_PREFIX, 8'(len), len > 127 ? 3 : 1);
      if (len <= 127) nt(8'(len), 8'h00, 8'h00, 1);
      if (nul) nt(TAG_NULL, NULL_LEN, 8'h00, 2);
      else nt(TAG_INVOKE_ID, ID_LEN, c == COMP_INVOKE ? own :
        c == COMP_REJECT ? last : inv, 3);
      if (c == COMP_INVOKE && lk) nt(TAG_LINKED_ID, ID_LEN, inv, 3);
      if (c == COMP_INVOKE || c == COMP_ERROR) nt(TAG_OP_VALUE, 8'h01,
        code, 3);
      if (c == COMP_INVOKE) own = own + 8'h01;
    end
    req = {c, lk, code, a};
    req_valid = 1'b1;
    while (req_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    while (req_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
  endtask
  task chk_desc(input comp_desc_s g);
    comp_desc_s e;
    e = 'x;
    if (dq.size() != 0) e = dq.pop_front();
    num_checks++;
    if (norm(g) !== e) begin
      num_errors++;
      $display("[ERR] %0t desc got %h exp %h", $time, norm(g), e);
    end
  endtask
  task chk_tx(input logic [8:0] g);
    logic [8:0] e;
    e = 'x;
    if (tq.size() != 0) e = tq.pop_front();
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t tx got %h exp %h", $time, g, e);
    end
  endtask
  task end_sim();
    if (num_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (!reset && desc_valid && desc_ready) chk_desc(desc);
    if (!reset && tx_valid && tx_ready) chk_tx({1'b0, tx_byte});
    if (!reset && enc_error) chk_tx(9'h100);
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      end_sim();
    end
  end
  initial begin
    ops = '{OP_VALUE_QUERY, OP_SET_VALUE, OP_REQUEST_FEATURE, OP_ABORT,
      OP_REDIRECT_CALL, OP_HOLD_CALLER, OP_RETRIEVE_HOLD, OP_DROP_TARGET,
      OP_CALL_STATUS, OP_USER_DATA};
    {reset, rx_valid, req_valid, slow, lnul} = 5'h10;
    {rx_byte, own, inv, last} = '0;
    req = '0;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    m = {TAG_INVOKE, 8'h03, TAG_INVOKE_ID, ID_LEN, 8'h05};
    comp(mk(COMP_INVOKE, 8'h03, 9'h005, 9'h0, 9'h0));
    m = {8'ha5, 8'h03, TAG_INVOKE_ID, ID_LEN, 8'h01};
    comp(bd());
    m = {TAG_INVOKE, 8'h82};
    comp(bd());
    m = {TAG_RESULT, 8'h04, TAG_INVOKE_ID, 8'h02, 8'h01, 8'h01};
    comp(bd());
    m = {TAG_REJECT, 8'h03, TAG_NULL, 8'h01, 8'h00};
    comp(bd());
    m = {TAG_INVOKE, LONG_PREFIX, 8'h80, TAG_INVOKE_ID, ID_LEN, 8'h33,
      TAG_OP_VALUE, 8'h01, OP_ABORT, 8'h04, 8'd120};
    repeat (120) m.push_back(8'($random(seed)));
    comp(mk(COMP_INVOKE, 8'h80, 9'h033, 9'h0, {1'b1, OP_ABORT}));
    idle();
    for (i = 0; i < 10; i++) begin
      id = 8'h40 + 8'(i);
      m = {TAG_INVOKE, 8'h09, TAG_INVOKE_ID, ID_LEN, id, TAG_LINKED_ID,
        ID_LEN, 8'h3f, TAG_OP_VALUE, 8'h01, ops[i]};
      comp(mk(COMP_INVOKE, 8'h09, {1'b0, id}, 9'h13f, {1'b1, ops[i]}));
      idle();
      enc(COMP_INVOKE, i[0], ops[i], 8'($random(seed) & 63));
    end
    m = {TAG_RESULT, 8'h08, TAG_INVOKE_ID, ID_LEN, 8'h49, 8'h30, 8'h03,
      TAG_OP_VALUE, 8'h01, OP_CALL_STATUS};
    comp(mk(COMP_RESULT, 8'h08, 9'h049, 9'h0, {1'b1, OP_CALL_STATUS}));
    m = {TAG_ERROR, 8'h06, TAG_INVOKE_ID, ID_LEN, 8'h41, TAG_ERR_VALUE,
      8'h01, 8'h07};
    comp(mk(COMP_ERROR, 8'h06, 9'h041, 9'h0, 9'h107));
    idle();
    slow = 1'b1;
    enc(COMP_RESULT, 1'b0, 8'h00, 8'd124);
    enc(COMP_RESULT, 1'b0, 8'h00, 8'd125);
    enc(COMP_ERROR, 1'b0, 8'h07, 8'd249);
    enc(COMP_RESULT, 1'b0, 8'h00, 8'd253);
    enc(COMP_REJECT, 1'b0, 8'h00, 8'h02);
    m = {TAG_REJECT, 8'h05, TAG_NULL, NULL_LEN, 8'h81, 8'h01, 8'h02};
    comp(mk(COMP_REJECT, 8'h05, 9'h100, 9'h0, 9'h0));
    idle();
    enc(COMP_REJECT, 1'b0, 8'h00, 8'h00);
    enc(COMP_INVOKE, 1'b1, OP_ABORT, 8'd200);
    while (tq.size() != 0) @(negedge clk);
    end_sim();
  end
endmodule // facility_component_codec_tb
